//--- hw/serial2_ir_regs.svh
`ifndef SERIAL2_IR_REGS_SVH
`define SERIAL2_IR_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define IDX_PORT2_MODE 8'hF0
`define IDX_IR_OPTION 8'hF1
`define IDX_HD_TIMEOUT 8'hF2

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define RST_PORT2_MODE 8'h00
`define RST_IR_OPTION 8'h02
`define RST_HD_TIMEOUT 8'h03

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define MODE_MIDI_BIT 0
`define MODE_HS_BIT 1
`define OPT_RXPOL_BIT 0
`define OPT_TXPOL_BIT 1
`define OPT_DUPLEX_BIT 2
`define OPT_IRMODE_LSB 3
`define OPT_IRMODE_MSB 5
`define OPT_LOC_BIT 6

// ----------------------------------------------------------------------------
// Infrared mode codes.
// ----------------------------------------------------------------------------
`define IRMODE_STD 3'h0
`define IRMODE_IRDA 3'h1
`define IRMODE_ASK 3'h2

// ----------------------------------------------------------------------------
// Timing: blanking step, longest blanking and clock period.
// ----------------------------------------------------------------------------
`define BLANK_STEP_NS 100000
`define BLANK_MAX_NS 10000000
`define MCLK_PERIOD_NS 100

`endif

//--- hw/serial2_ir_pkg.sv
package serial2_ir_pkg;

  // --------------------------------------------------------------------------
  // Register contents and decoded modes.
  // --------------------------------------------------------------------------

  // Decoded infrared encoding.
  typedef enum logic [1:0] {IR_STANDARD, IR_IRDA, IR_ASK, IR_RESERVED} ir_mode_e;

  // Port mode register: implemented bits only.
  typedef struct packed {
    logic high_speed;
    logic midi;
  } mode_s;

  // Infrared option register: implemented bits only.
  typedef struct packed {
    logic alt_pins;
    logic [2:0] ir_mode;
    logic half_duplex;
    logic tx_active_low;
    logic rx_active_low;
  } opt_s;

  // All configuration state.
  typedef struct packed {
    mode_s mode;
    opt_s opt;
    logic [7:0] timeout;
  } cfg_s;

  // Whole state of the top module.
  typedef struct packed {
    cfg_s cfg;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic [1:0] hbr_sync;
    logic [1:0] rx_sync;
    logic [1:0] alt_rx_sync;
    logic tx_pin;
    logic alt_tx_pin;
    logic rxd;
  } state_s;

endpackage : serial2_ir_pkg

//--- hw/ir_blank_timer.sv
`timescale 1ns/1ps
`include "serial2_ir_regs.svh"

// Receive blanking for half duplex: active while transmitting and for a
// programmed number of steps after transmission ends.
module ir_blank_timer #(
  parameter int UNIT_CYCLES = (`BLANK_STEP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic tx_active,
  input wire logic [7:0] units,
  output logic blank
);

  // --------------------------------------------------------------------------
  // Parameter check.
  // --------------------------------------------------------------------------
  if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535)
  begin : g_bad_unit
    $error("UNIT_CYCLES must lie between 1 and 65535.");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_HOLD} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [7:0] units_left;
    logic [15:0] cycles_left;
  } tstate_s;

  tstate_s s_q, s_d;

  // Next state of the blanking sequencer.
  always_comb
  begin
    s_d = s_q;
    case (s_q.phase)
      ST_IDLE:
      begin
        if (enable && tx_active)
        begin
          s_d.phase = ST_TX;
        end
      end
      ST_TX:
      begin
        // Transmission ended: zero steps means no extra blanking.
        if (!tx_active)
        begin
          s_d.units_left = units;
          s_d.cycles_left = 16'(UNIT_CYCLES - 1);
          s_d.phase = (units == 8'h00) ? ST_IDLE : ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        if (tx_active)
        begin
          s_d.phase = ST_TX;
        end
        else if (s_q.cycles_left != 16'h0000)
        begin
          s_d.cycles_left = s_q.cycles_left - 16'h0001;
        end
        else if (s_q.units_left <= 8'h01)
        begin
          s_d.phase = ST_IDLE;
        end
        else
        begin
          // One more step of the programmed delay.
          s_d.units_left = s_q.units_left - 8'h01;
          s_d.cycles_left = 16'(UNIT_CYCLES - 1);
        end
      end
      default:
      begin
        s_d.phase = ST_IDLE;
      end
    endcase
    if (!enable)
    begin
      s_d.phase = ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q <= '{phase: ST_IDLE, units_left: 8'h00, cycles_left: 16'h0000};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Blank while transmitting and during the hold time.
  assign blank = enable && (tx_active || s_q.phase != ST_IDLE);

endmodule : ir_blank_timer

//--- hw/serial2_ir_config.sv
`timescale 1ns/1ps
`include "serial2_ir_regs.svh"

module serial2_ir_config #(
  parameter int UNIT_CYCLES = (`BLANK_STEP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,
  parameter int MAX_UNITS = `BLANK_MAX_NS / `BLANK_STEP_NS
) (
  input wire logic mclk,
  input wire logic nrst,
  // Host bus reset from outside; reloads the three configuration registers.
  input wire logic host_bus_reset,
  // AHB-Lite slave port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // UART core side, same clock.
  input wire logic uart_txd,
  input wire logic uart_tx_active,
  output logic uart_rxd,
  output logic midi_enable,
  output logic high_speed_enable,
  output serial2_ir_pkg::ir_mode_e ir_mode,
  // Line side pins.
  output logic port2_transmit_pin,
  input wire logic port2_receive_pin,
  output logic alt_infrared_transmit_pin,
  input wire logic alt_infrared_receive_pin
);

  // --------------------------------------------------------------------------
  // Parameter checks.
  // --------------------------------------------------------------------------
  if (MAX_UNITS < 1 || MAX_UNITS > 255)
  begin : g_bad_max
    $error("MAX_UNITS must lie between 1 and 255.");
  end

  // --------------------------------------------------------------------------
  // Helper functions.
  // --------------------------------------------------------------------------

  // Register index of a bus address, or zero when not word aligned in range.
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    logic [7:0] idx;
    idx = 8'h00;
    if (addr[31:10] == 22'h000000 && addr[1:0] == 2'b00)
    begin
      idx = addr[9:2];
    end
    return idx;
  endfunction : reg_index

  // Decode of the three-bit infrared mode field.
  function automatic serial2_ir_pkg::ir_mode_e decode_mode(input logic [2:0] code);
    serial2_ir_pkg::ir_mode_e m;
    case (code)
      `IRMODE_STD: m = serial2_ir_pkg::IR_STANDARD;
      `IRMODE_IRDA: m = serial2_ir_pkg::IR_IRDA;
      `IRMODE_ASK: m = serial2_ir_pkg::IR_ASK;
      default: m = serial2_ir_pkg::IR_RESERVED;
    endcase
    return m;
  endfunction : decode_mode

  // Configuration after any reset.
  function automatic serial2_ir_pkg::cfg_s cfg_reset();
    serial2_ir_pkg::cfg_s c;
    c.mode = serial2_ir_pkg::mode_s'(2'(`RST_PORT2_MODE));
    c.opt = serial2_ir_pkg::opt_s'(7'(`RST_IR_OPTION));
    c.timeout = `RST_HD_TIMEOUT;
    return c;
  endfunction : cfg_reset

  // --------------------------------------------------------------------------
  // State and wires.
  // --------------------------------------------------------------------------

  // All registers of the block.
  serial2_ir_pkg::state_s s_q, s_d;

  // Address phase accepted this cycle.
  logic addr_take;

  // Receive blanking request from the timer.
  logic rx_blank;

  // Timeout value clamped to the longest delay.
  logic [7:0] units_clamped;

  // Decoded encoding in use.
  serial2_ir_pkg::ir_mode_e mode_now;

  // True for an infrared encoding.
  logic ir_on;

  // Raw level of the selected receive pin, already synchronised.
  logic rx_raw;

  // Light seen on the receiver after polarity.
  logic rx_light;

  // Light to send on the transmitter.
  logic tx_light;

  // Transmit pin level after polarity.
  logic tx_level;

  // Read data for the decoded index.
  logic [31:0] rd_word;

  // --------------------------------------------------------------------------
  // Line side decode.
  // --------------------------------------------------------------------------

  // Encoding chosen by the mode field; reserved codes act as standard.
  assign mode_now = decode_mode(s_q.cfg.opt.ir_mode);

  // Only the two defined infrared encodings drive the optics.
  assign ir_on = (mode_now == serial2_ir_pkg::IR_IRDA) || (mode_now == serial2_ir_pkg::IR_ASK);

  // Receive source follows the location select in infrared modes.
  assign rx_raw = (ir_on && s_q.cfg.opt.alt_pins) ? s_q.alt_rx_sync[1] : s_q.rx_sync[1];

  // Polarity of the infrared receiver.
  assign rx_light = s_q.cfg.opt.rx_active_low ? ~rx_raw : rx_raw;

  // A space on the serial line is sent as light.
  assign tx_light = ir_on && !uart_txd;

  // Polarity of the infrared transmitter.
  assign tx_level = s_q.cfg.opt.tx_active_low ? ~tx_light : tx_light;

  // Timeouts past the longest delay are held at the limit.
  assign units_clamped = (s_q.cfg.timeout > 8'(MAX_UNITS)) ? 8'(MAX_UNITS) : s_q.cfg.timeout;

  // --------------------------------------------------------------------------
  // Half duplex blanking timer.
  // --------------------------------------------------------------------------

  // Blanking only runs in half duplex with an infrared encoding.
  ir_blank_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_blank (
    .mclk(mclk),
    .nrst(nrst),
    .enable(ir_on && s_q.cfg.opt.half_duplex),
    .tx_active(uart_tx_active),
    .units(units_clamped),
    .blank(rx_blank)
  );

  // --------------------------------------------------------------------------
  // Bus decode.
  // --------------------------------------------------------------------------

  // A transfer is taken when selected, active and the bus is ready.
  assign addr_take = hsel && htrans[1] && hready;

  // Read mux; unmapped indices and reserved bits read as zero.
  always_comb
  begin
    rd_word = 32'h00000000;
    case (reg_index(haddr))
      `IDX_PORT2_MODE:
      begin
        // Two live mode bits.
        rd_word[`MODE_MIDI_BIT] = s_q.cfg.mode.midi;
        rd_word[`MODE_HS_BIT] = s_q.cfg.mode.high_speed;
      end
      `IDX_IR_OPTION:
      begin
        // Seven live option bits.
        rd_word[`OPT_RXPOL_BIT] = s_q.cfg.opt.rx_active_low;
        rd_word[`OPT_TXPOL_BIT] = s_q.cfg.opt.tx_active_low;
        rd_word[`OPT_DUPLEX_BIT] = s_q.cfg.opt.half_duplex;
        rd_word[`OPT_IRMODE_MSB:`OPT_IRMODE_LSB] = s_q.cfg.opt.ir_mode;
        rd_word[`OPT_LOC_BIT] = s_q.cfg.opt.alt_pins;
      end
      `IDX_HD_TIMEOUT:
      begin
        // Full timeout byte.
        rd_word[7:0] = s_q.cfg.timeout;
      end
      default:
      begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state.
  // --------------------------------------------------------------------------

  // Bus writes, synchronisers and registered pin levels.
  always_comb
  begin
    s_d = s_q;

    // Two flip-flops on every input from outside the clock domain.
    s_d.hbr_sync = {s_q.hbr_sync[0], host_bus_reset};
    s_d.rx_sync = {s_q.rx_sync[0], port2_receive_pin};
    s_d.alt_rx_sync = {s_q.alt_rx_sync[0], alt_infrared_receive_pin};

    // Data phase of a write stores the low byte.
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend)
    begin
      case (s_q.wr_idx)
        `IDX_PORT2_MODE:
        begin
          // Upper mode bits are dropped.
          s_d.cfg.mode.midi = hwdata[`MODE_MIDI_BIT];
          s_d.cfg.mode.high_speed = hwdata[`MODE_HS_BIT];
        end
        `IDX_IR_OPTION:
        begin
          // Option bit 7 is dropped.
          s_d.cfg.opt.rx_active_low = hwdata[`OPT_RXPOL_BIT];
          s_d.cfg.opt.tx_active_low = hwdata[`OPT_TXPOL_BIT];
          s_d.cfg.opt.half_duplex = hwdata[`OPT_DUPLEX_BIT];
          s_d.cfg.opt.ir_mode = hwdata[`OPT_IRMODE_MSB:`OPT_IRMODE_LSB];
          s_d.cfg.opt.alt_pins = hwdata[`OPT_LOC_BIT];
        end
        `IDX_HD_TIMEOUT:
        begin
          // All eight bits are kept.
          s_d.cfg.timeout = hwdata[7:0];
        end
        default:
        begin
          // Writes to unmapped indices are dropped.
          s_d.cfg = s_q.cfg;
        end
      endcase
    end

    // Address phase: latch a write, or capture read data.
    if (addr_take)
    begin
      s_d.wr_pend = hwrite;
      s_d.wr_idx = reg_index(haddr);
      if (!hwrite)
      begin
        // Read data stands from the next cycle.
        s_d.rdata = rd_word;
      end
    end

    // Host bus reset reloads the reset defaults over any write.
    if (s_q.hbr_sync[1])
    begin
      s_d.cfg = cfg_reset();
    end

    // Serial pin idles at mark whenever infrared owns the other pins.
    s_d.tx_pin = (ir_on && s_q.cfg.opt.alt_pins) ? 1'b1 : (ir_on ? tx_level : uart_txd);

    // Alternate transmitter rests at the dark level when unused.
    s_d.alt_tx_pin = (ir_on && s_q.cfg.opt.alt_pins) ? tx_level : s_q.cfg.opt.tx_active_low;

    // Received bit: light means space; blanked input reads as mark.
    if (rx_blank)
    begin
      s_d.rxd = 1'b1;
    end
    else
    begin
      s_d.rxd = ir_on ? ~rx_light : rx_raw;
    end
  end

  // --------------------------------------------------------------------------
  // State register.
  // --------------------------------------------------------------------------

  // Power-on reset loads constants only.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q.cfg.mode <= serial2_ir_pkg::mode_s'(2'(`RST_PORT2_MODE));
      s_q.cfg.opt <= serial2_ir_pkg::opt_s'(7'(`RST_IR_OPTION));
      s_q.cfg.timeout <= `RST_HD_TIMEOUT;
      s_q.wr_pend <= 1'b0;
      s_q.wr_idx <= 8'h00;
      s_q.rdata <= 32'h00000000;
      s_q.hbr_sync <= 2'b00;
      // Receive chains idle at mark.
      s_q.rx_sync <= 2'b11;
      s_q.alt_rx_sync <= 2'b11;
      s_q.tx_pin <= 1'b1;
      s_q.alt_tx_pin <= 1'b1;
      s_q.rxd <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs.
  // --------------------------------------------------------------------------

  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;

  // Configuration seen by the UART core.
  assign midi_enable = s_q.cfg.mode.midi;
  assign high_speed_enable = s_q.cfg.mode.high_speed;
  assign ir_mode = mode_now;

  // Registered line levels.
  assign port2_transmit_pin = s_q.tx_pin;
  assign alt_infrared_transmit_pin = s_q.alt_tx_pin;
  assign uart_rxd = s_q.rxd;

endmodule : serial2_ir_config

//--- tb/serial2_ir_config_sva.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Checker on the top ports of the configuration block.
// ----------------------------------------------------------------------------
module serial2_ir_chk #(
  parameter int UNIT_CYCLES = 1000,
  parameter int MAX_UNITS = 100
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic host_bus_reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic uart_txd,
  input wire logic uart_tx_active,
  input wire logic uart_rxd,
  input wire logic midi_enable,
  input wire logic high_speed_enable,
  input wire serial2_ir_pkg::ir_mode_e ir_mode,
  input wire logic port2_transmit_pin,
  input wire logic port2_receive_pin,
  input wire logic alt_infrared_transmit_pin
);
  // Write data phase marker and a saturating count of cycles since reset.
  logic wr_dp_q;
  logic [2:0] up_q;

  // Helper state, so that history from before reset is never trusted.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_dp_q <= 1'b0;
      up_q <= 3'h0;
    end
    else
    begin
      wr_dp_q <= hsel && htrans[1] && hready && hwrite;
      up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  bus_reload_a: assert property (host_bus_reset [*5] |-> !midi_enable && !high_speed_enable &&
    ir_mode == serial2_ir_pkg::IR_STANDARD) else $error("host reset did not reload");
  cfg_cause_a: assert property ($changed({midi_enable, high_speed_enable, ir_mode}) |->
    $past(wr_dp_q) || $past(host_bus_reset, 2) || $past(host_bus_reset, 3) || $past(host_bus_reset, 4))
    else $error("config output changed without a write");
  rdata_cause_a: assert property ($changed(hrdata) |->
    $past(hsel && htrans[1] && hready && !hwrite)) else $error("read data changed without a read");
  std_tx_a: assert property (up_q == 3'h7 && $past(ir_mode) inside {serial2_ir_pkg::IR_STANDARD,
    serial2_ir_pkg::IR_RESERVED} |-> port2_transmit_pin == $past(uart_txd)) else $error("standard tx wrong");
  std_rx_a: assert property (up_q == 3'h7 && $past(ir_mode) inside {serial2_ir_pkg::IR_STANDARD,
    serial2_ir_pkg::IR_RESERVED} |-> uart_rxd == $past(port2_receive_pin, 3)) else $error("standard rx wrong");
  ir_tx_a: assert property (up_q == 3'h7 && $past(ir_mode) inside {serial2_ir_pkg::IR_IRDA,
    serial2_ir_pkg::IR_ASK} && !$past(wr_dp_q, 2) && $past(uart_txd) != $past(uart_txd, 2)
    |-> port2_transmit_pin != $past(port2_transmit_pin) || alt_infrared_transmit_pin !=
    $past(alt_infrared_transmit_pin)) else $error("infrared tx did not follow");
  alt_rest_a: assert property (up_q == 3'h7 && $past(ir_mode) == serial2_ir_pkg::IR_STANDARD &&
    !$past(wr_dp_q, 2) |-> $stable(alt_infrared_transmit_pin)) else $error("alt tx moved in standard mode");

  blank_end_c: cover property (uart_tx_active ##1 !uart_tx_active ##[1:20] !uart_rxd);
  reload_c: cover property (host_bus_reset [*5]);
  ask_mode_c: cover property (ir_mode == serial2_ir_pkg::IR_ASK);
endmodule : serial2_ir_chk

bind serial2_ir_config serial2_ir_chk #(.UNIT_CYCLES(UNIT_CYCLES), .MAX_UNITS(MAX_UNITS)) chk (
  .mclk(mclk), .nrst(nrst), .host_bus_reset(host_bus_reset), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .uart_txd(uart_txd), .uart_tx_active(uart_tx_active), .uart_rxd(uart_rxd), .midi_enable(midi_enable),
  .high_speed_enable(high_speed_enable), .ir_mode(ir_mode), .port2_transmit_pin(port2_transmit_pin),
  .port2_receive_pin(port2_receive_pin), .alt_infrared_transmit_pin(alt_infrared_transmit_pin));

//--- tb/ir_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Far side: transceiver on the chosen pin pair; the idle receive pin churns.
// ----------------------------------------------------------------------------
module ir_line_model (
  input wire logic mclk,
  input wire logic light,
  input wire logic active_low,
  input wire logic use_alt,
  output logic port2_receive_pin,
  output logic alt_infrared_receive_pin
);
  // The unused input toggles every cycle so a stale level never passes.
  logic churn_q = 1'b0;

  // Pattern for the pin that is not selected.
  always_ff @(posedge mclk)
    churn_q <= ~churn_q;

  // Light shows on the selected pin in the transceiver's polarity.
  always_comb
  begin
    port2_receive_pin = use_alt ? churn_q : light ^ active_low;
    alt_infrared_receive_pin = use_alt ? light ^ active_low : churn_q;
  end
endmodule : ir_line_model

//--- tb/tb.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Self-checking bench for the second port configuration block.
// ----------------------------------------------------------------------------
module tb;
  localparam int UNIT = 4;
  localparam logic [31:0] A_MODE = 32'h000003C0;
  localparam logic [31:0] A_OPT = 32'h000003C4;
  localparam logic [31:0] A_TMO = 32'h000003C8;
  localparam logic [31:0] A_NONE = 32'h000003CC;
  logic mclk = 1'b0, nrst = 1'b0, host_bus_reset = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, uart_txd = 1'b1, uart_tx_active = 1'b0, uart_rxd, midi_enable, high_speed_enable;
  logic port2_transmit_pin, port2_receive_pin, alt_infrared_transmit_pin, alt_infrared_receive_pin;
  logic light = 1'b1, mdl_low = 1'b0, mdl_alt = 1'b0;
  serial2_ir_pkg::ir_mode_e ir_mode;
  int errors = 0;
  int checks_done = 0;

  // Clock at 100 ns period.
  always #50 mclk = ~mclk;

  serial2_ir_config #(.UNIT_CYCLES(UNIT)) DUT (.mclk(mclk), .nrst(nrst), .host_bus_reset(host_bus_reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .uart_txd(uart_txd),
    .uart_tx_active(uart_tx_active), .uart_rxd(uart_rxd), .midi_enable(midi_enable),
    .high_speed_enable(high_speed_enable), .ir_mode(ir_mode), .port2_transmit_pin(port2_transmit_pin),
    .port2_receive_pin(port2_receive_pin), .alt_infrared_transmit_pin(alt_infrared_transmit_pin),
    .alt_infrared_receive_pin(alt_infrared_receive_pin));

  ir_line_model far_side (.mclk(mclk), .light(light), .active_low(mdl_low), .use_alt(mdl_alt),
    .port2_receive_pin(port2_receive_pin), .alt_infrared_receive_pin(alt_infrared_receive_pin));

  // --------------------------------------------------------------------------
  // Common tasks.
  // --------------------------------------------------------------------------
  task automatic wrap_up();
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : check

  // Waits for an edge with hready high, bounded.
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      wrap_up();
    end
  endtask : wait_ready

  // One single-word transfer: address phase, then data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    check(what, exp, x);
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk("mode", A_MODE, 32'h00000000);
    rd_chk("option", A_OPT, 32'h00000002);
    rd_chk("timeout", A_TMO, 32'h00000003);
    wr(A_NONE, 32'h000000FF);
    rd_chk("unmapped", A_NONE, 32'h00000000);
    check("ir_mode", 32'h0, {30'h0, ir_mode});
  endtask : t_reset_values

  task automatic t_mode();
    for (int v = 0; v < 4; v++)
    begin
      wr(A_MODE, v);
      tick(2);
      check("midi", v & 1, {31'h0, midi_enable});
      check("high speed", v >> 1, {31'h0, high_speed_enable});
      rd_chk("mode back", A_MODE, v);
    end
  endtask : t_mode

  task automatic t_ir_modes();
    logic [1:0] em;
    for (int c = 0; c < 8; c++)
    begin
      wr(A_OPT, {24'h0, 2'b00, c[2:0], 3'b010});
      tick(2);
      em = (c > 2) ? 2'h3 : c[1:0];
      check("ir_mode", {30'h0, em}, {30'h0, ir_mode});
      rd_chk("option back", A_OPT, {24'h0, 2'b00, c[2:0], 3'b010});
    end
  endtask : t_ir_modes

  task automatic t_tx();
    logic pol, alt, lit;
    for (int k = 0; k < 8; k++)
    begin
      {lit, alt, pol} = k[2:0];
      wr(A_OPT, {24'h0, 1'b0, alt, 3'b001, 1'b0, pol, 1'b0});
      @(posedge mclk);
      uart_txd <= ~lit;
      tick(3);
      check("alt tx", {31'h0, alt ? lit ^ pol : pol}, {31'h0, alt_infrared_transmit_pin});
      check("port2 tx", {31'h0, alt ? 1'b1 : lit ^ pol}, {31'h0, port2_transmit_pin});
    end
    @(posedge mclk);
    uart_txd <= 1'b1;
  endtask : t_tx

  task automatic t_rx();
    logic pol, alt, lit;
    for (int k = 0; k < 8; k++)
    begin
      {lit, alt, pol} = k[2:0];
      wr(A_OPT, {24'h0, 1'b0, alt, 3'b001, 1'b0, 1'b1, pol});
      @(posedge mclk);
      mdl_low <= pol;
      mdl_alt <= alt;
      light <= lit;
      tick(5);
      check("ir rx", {31'h0, ~lit}, {31'h0, uart_rxd});
    end
  endtask : t_rx

  task automatic t_std();
    wr(A_OPT, 32'h00000002);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge mclk);
      mdl_low <= 1'b0;
      mdl_alt <= 1'b0;
      light <= b[0];
      uart_txd <= b[0];
      tick(5);
      check("std tx", b, {31'h0, port2_transmit_pin});
      check("std rx", b, {31'h0, uart_rxd});
    end
  endtask : t_std

  // Light held on, so an unblanked receiver shows 0.
  task automatic t_blank(input logic [7:0] opt, input logic [7:0] tmo, input int lo, input int hi);
    int n;
    wr(A_OPT, {24'h0, opt});
    wr(A_TMO, {24'h0, tmo});
    @(posedge mclk);
    light <= 1'b1;
    uart_tx_active <= 1'b1;
    tick(6);
    check("rx during tx", {31'h0, opt[2]}, {31'h0, uart_rxd});
    @(posedge mclk);
    uart_tx_active <= 1'b0;
    n = 0;
    while (uart_rxd !== 1'b0 && n < 600)
    begin
      tick(1);
      n++;
    end
    checks_done++;
    if (n < lo || n > hi)
    begin
      $display("CHECK FAILED blank cycles expected %0d to %0d seen %0d", lo, hi, n);
      errors++;
    end
  endtask : t_blank

  task automatic t_bus_reset();
    wr(A_MODE, 32'h00000003);
    wr(A_OPT, 32'h0000004F);
    wr(A_TMO, 32'h00000055);
    @(posedge mclk);
    host_bus_reset <= 1'b1;
    tick(4);
    wr(A_MODE, 32'h00000003);
    tick(2);
    @(posedge mclk);
    host_bus_reset <= 1'b0;
    tick(4);
    rd_chk("mode reload", A_MODE, 32'h00000000);
    rd_chk("option reload", A_OPT, 32'h00000002);
    rd_chk("timeout reload", A_TMO, 32'h00000003);
  endtask : t_bus_reset

  // --------------------------------------------------------------------------
  // Main sequence and hang limit.
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_values();
    t_mode();
    t_ir_modes();
    t_tx();
    t_rx();
    t_std();
    t_blank(8'h0C, 8'h00, 1, 3);
    t_blank(8'h0C, 8'h01, UNIT + 1, UNIT + 3);
    t_blank(8'h0C, 8'h03, 3 * UNIT + 1, 3 * UNIT + 3);
    t_blank(8'h0C, 8'hC8, 100 * UNIT + 1, 100 * UNIT + 3);
    t_blank(8'h08, 8'h03, 0, 0);
    t_bus_reset();
    wrap_up();
  end

  initial
  begin
    #(100 * 90000);
    errors++;
    wrap_up();
  end
endmodule : tb
